// >>> verification/shift_checker_sva.sv
`timescale 1ns/1ps
// watches the top ports only; single clock domain
module shift_checker #(
   parameter int LENGTH = 25
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic phase_one,
   input wire logic phase_two,
   input wire logic src_ready,
   input wire logic data_out_a,
   input wire logic data_out_b,
   input wire logic starved,
   input wire logic overlap_seen
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // both pins held high long enough to pass the filter
   sequence s_both;
      (phase_one && phase_two) [*6];
   endsequence
   property p_move_a;
      $changed(data_out_a) |-> $past(phase_one, 3);
   endproperty
   property p_move_b;
      $changed(data_out_b) |-> $past(phase_one, 3);
   endproperty
   property p_flag_overlap;
      s_both |-> overlap_seen;
   endproperty
   property p_flag_clear;
      (!phase_one) [*6] |-> !overlap_seen;
   endproperty
   property p_starved_pulse;
      starved |=> !starved;
   endproperty
   property p_starved_cause;
      starved |-> $past(phase_two, 3);
   endproperty
   property p_ready_reset;
      $rose(rst_b) |-> src_ready;
   endproperty
   a_move_a: assert property (p_move_a) else $error("out a moved off phase one");
   a_move_b: assert property (p_move_b) else $error("out b moved off phase one");
   a_flag_overlap: assert property (p_flag_overlap) else $error("overlap not flagged");
   a_flag_clear: assert property (p_flag_clear) else $error("overlap flag stuck");
   a_starved_pulse: assert property (p_starved_pulse) else $error("starved too long");
   a_starved_cause: assert property (p_starved_cause) else $error("starved off phase");
   a_ready_reset: assert property (p_ready_reset) else $error("not ready after reset");
endmodule // shift_checker

// >>> verification/shift_source.sv
`timescale 1ns/1ps
// far side: serial source and two-phase clock pair
module shift_source (
   input  wire logic clock,
   output logic      phase_one,
   output logic      phase_two,
   output logic      data_in_a,
   output logic      data_in_b,
   output logic      src_valid
);
   initial begin
      {phase_one, phase_two, data_in_a, data_in_b, src_valid} = 5'h00;
   end
   // drive the given phase pins for n cycles, then both low for two
   task automatic pulse(input logic one, input logic two, input int n);
      @(negedge clock);
      phase_one = one;
      phase_two = two;
      repeat (n) @(negedge clock);
      phase_one = 1'b0;
      phase_two = 1'b0;
      repeat (2) @(negedge clock);
   endtask
   // one word offered; released data shows the inverse, not a stale copy
   task automatic push(input logic a, input logic b);
      @(negedge clock);
      {src_valid, data_in_a, data_in_b} = {1'b1, a, b};
      @(negedge clock);
      {src_valid, data_in_a, data_in_b} = {1'b0, ~a, ~b};
   endtask
endmodule // shift_source

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   localparam int LENGTH = 25;
   logic clock, rst_b, phase_one, phase_two, data_in_a, data_in_b, src_valid;
   logic src_ready, data_out_a, data_out_b, starved, overlap_seen;
   int   failures, checked, starves;
   logic hist_a[$], hist_b[$], pend_a[$], pend_b[$];
   dual_shift_register #(.LENGTH(LENGTH)) uut (.clock(clock), .rst_b(rst_b),
      .phase_one(phase_one), .phase_two(phase_two), .data_in_a(data_in_a),
      .data_in_b(data_in_b), .src_valid(src_valid), .src_ready(src_ready),
      .data_out_a(data_out_a), .data_out_b(data_out_b), .starved(starved),
      .overlap_seen(overlap_seen));
   shift_source src (.clock(clock), .phase_one(phase_one), .phase_two(phase_two),
      .data_in_a(data_in_a), .data_in_b(data_in_b), .src_valid(src_valid));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // count starved pulses, sampled at the falling edge where they settled
   always @(negedge clock) if (starved === 1'b1) starves++;
   task automatic check(input logic seen, input logic exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %b expected %b", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // output of the last cell: bit loaded LENGTH-1 pairs back, zero before
   function automatic logic out_exp(input logic q[$]);
      return (q.size() >= LENGTH) ? q[q.size() - LENGTH] : 1'b0;
   endfunction
   // one bit time: optional word, phase two, then phase one
   task automatic pair(input logic go, input logic a, input logic b);
      logic pa, pb;
      pa = out_exp(hist_a);
      pb = out_exp(hist_b);
      if (go) begin
         src.push(a, b);
         pend_a.push_back(a);
         pend_b.push_back(b);
      end
      src.pulse(1'b0, 1'b1, 6);
      hist_a.push_back(pend_a.size() ? pend_a.pop_front() : 1'b0);
      hist_b.push_back(pend_b.size() ? pend_b.pop_front() : 1'b0);
      check(data_out_a, pa);
      check(data_out_b, pb);
      src.pulse(1'b1, 1'b0, 6);
      check(data_out_a, out_exp(hist_a));
      check(data_out_b, out_exp(hist_b));
   endtask
   task automatic test_reset;
      check(src_ready, 1'b1);
      check(data_out_a | data_out_b | starved | overlap_seen, 1'b0);
      $display("test_reset done");
   endtask
   task automatic test_fill_drain;
      int n;
      n = 0;
      while (src_ready === 1'b1 && n < 40) begin
         src.push(1'b1, 1'b0);
         pend_a.push_back(1'b1);
         pend_b.push_back(1'b0);
         n++;
      end
      // a fifo that never fills counts once and the run goes on
      if (n >= 40) begin
         failures++;
      end
      check(n >= 32, 1'b1);
      for (int k = 0; k < n + 3; k++) pair(1'b0, 1'b0, 1'b0);
      check(starves > 0, 1'b1);
      $display("test_fill_drain done");
   endtask
   task automatic test_pattern;
      for (int k = 0; k < 30; k++) pair(1'b1, k[0] ^ k[2], k[1]);
      $display("test_pattern done");
   endtask
   task automatic test_overlap;
      fork
         src.pulse(1'b1, 1'b1, 8);
         begin
            repeat (8) @(negedge clock);
            check(overlap_seen, 1'b1);
         end
      join
      check(data_out_a, out_exp(hist_a));
      pair(1'b1, 1'b1, 1'b1);
      check(overlap_seen, 1'b0);
      $display("test_overlap done");
   endtask
   initial begin
      {failures, checked, starves} = 0;
      rst_b = 1'b0;
      repeat (20) @(negedge clock);
      rst_b = 1'b1;
      test_reset();
      test_fill_drain();
      test_pattern();
      test_overlap();
      end_of_test();
   end
endmodule // testbench
bind dual_shift_register shift_checker #(.LENGTH(LENGTH)) chk (.clock(clock),
   .rst_b(rst_b), .phase_one(phase_one), .phase_two(phase_two),
   .src_ready(src_ready), .data_out_a(data_out_a), .data_out_b(data_out_b),
   .starved(starved), .overlap_seen(overlap_seen));

// >>> verilog/dual_shift_defs.svh
`ifndef DUAL_SHIFT_DEFS_SVH
`define DUAL_SHIFT_DEFS_SVH
// cells per half, one of the standard lengths
`define SHIFT_LEN_SHORT     25
`define SHIFT_LEN_MID       50
`define SHIFT_LEN_LONG      100
`define SHIFT_LEN_DEFAULT   `SHIFT_LEN_SHORT
// least refresh rate of the two-phase clock, in hertz
`define SHIFT_MIN_RATE_HZ   600
// one fifo in front of both halves, one bit per half
`define SHIFT_FIFO_DEPTH    32
`define SHIFT_FIFO_WIDTH    2
`endif

// >>> verilog/dual_shift_pkg.sv
package dual_shift_pkg;
   // synchronised phase pair as seen by the cells
   typedef enum logic [2:0] {
      PH_IDLE = 3'h1,
      PH_ONE  = 3'h2,
      PH_TWO  = 3'h4
   } phase_t;
endpackage

// >>> verilog/dual_shift_register.sv
`timescale 1ns/1ps
`include "dual_shift_defs.svh"
// two serial delay lines of two-stage cells, run by a two-phase clock.
// phase pins arrive from outside, so they pass three flops and a phase
// counts as active once the second and third flops agree.
//
// timing of one phase pulse, in system clock edges after the pin moves:
//   edges 1 to 3  the pin walks through the three sync flops
//   edge 4        flops two and three agree, the filtered level moves
//   edge 5        the phase state moves and the cells transfer
// each pulse must stand for several system clocks so that the filter
// sees it, and the old level must fall before the next pulse starts.
//
// a bit loaded at a phase-two pulse sits in the first stage of cell 0,
// moves to its second stage at the next phase-one pulse, and leaves
// the last cell after LENGTH phase-one pulses in all.
//
// limitation: the real cells are dynamic; these are static flops, so
// a stalled clock source loses nothing here. the reset exists only to
// give simulation a defined start.
module dual_shift_register #(
   parameter int LENGTH = `SHIFT_LEN_DEFAULT
) (
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic phase_one,        // first clock phase pin
   input  wire logic phase_two,        // second clock phase pin
   input  wire logic data_in_a,        // serial input, half a
   input  wire logic data_in_b,        // serial input, half b
   input  wire logic src_valid,        // source offers a bit pair
   output logic      src_ready,        // fifo has room
   output logic      data_out_a,       // serial output, half a
   output logic      data_out_b,       // serial output, half b
   output logic      starved,          // phase two came with fifo empty
   output logic      overlap_seen      // both phases seen high together
);
   localparam int W = `SHIFT_FIFO_WIDTH;

   // three-flop synchronisers for the phase pins; bit 0 meets the pin
   // and only bit 1 reads it, the filter compares bits 1 and 2
   logic [2:0] sync_one;               // phase one sample chain
   logic [2:0] sync_two;               // phase two sample chain
   logic [2:0] next_sync_one;          // chain after the next shift
   logic [2:0] next_sync_two;          // chain after the next shift
   logic       one_level;              // agreed level of phase one
   logic       two_level;              // agreed level of phase two
   logic       next_one_level;         // filter result, phase one
   logic       next_two_level;         // filter result, phase two

   // phase state and edge detection
   dual_shift_pkg::phase_t phase;
   dual_shift_pkg::phase_t next_phase;
   logic       two_rise;               // start of a phase two pulse
   logic       one_rise;               // start of a phase one pulse

   // cell stages: first (node a) and second (node g) per half
   logic [LENGTH-1:0] first_a;
   logic [LENGTH-1:0] second_a;
   logic [LENGTH-1:0] first_b;
   logic [LENGTH-1:0] second_b;
   logic [LENGTH-1:0] next_first_a;
   logic [LENGTH-1:0] next_second_a;
   logic [LENGTH-1:0] next_first_b;
   logic [LENGTH-1:0] next_second_b;
   logic              next_starved;
   logic              next_overlap;

   // fifo side; bit 0 of a word feeds half a, bit 1 half b
   logic [W-1:0] fifo_data;            // word at the fifo head
   logic         fifo_valid;           // head word present
   logic         fifo_take;            // head word consumed
   logic [W-1:0] cell_in;              // input bits seen by first cells

   // input buffer; the phase-two load drains it, so a slow clock
   // source stalls the data source through src_ready
   // capacity is the fifo depth plus its output register
   shift_fifo #(
      .WIDTH (W),
      .DEPTH (`SHIFT_FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .rst_b     (rst_b),
      .in_data   ({data_in_b, data_in_a}),
      .in_valid  (src_valid),
      .in_ready  (src_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_take)
   );

   // level filter: change only when flops two and three agree, so a
   // glitch caught by a single sample never moves the phase level
   always_comb begin
      // shift the pins in; bit 0 may be metastable, bit 1 settles it
      next_sync_one  = {sync_one[1:0], phase_one};
      next_sync_two  = {sync_two[1:0], phase_two};
      next_one_level = (sync_one[1] == sync_one[2]) ? sync_one[2] : one_level;
      next_two_level = (sync_two[1] == sync_two[2]) ? sync_two[2] : two_level;
   end

   // synchroniser and filtered level registers; they reset low, the
   // idle level of the pins, so no false phase edge follows reset
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sync_one  <= 3'h0;
         sync_two  <= 3'h0;
         one_level <= 1'b0;
         two_level <= 1'b0;
      end else begin
         sync_one  <= next_sync_one;
         sync_two  <= next_sync_two;
         one_level <= next_one_level;
         two_level <= next_two_level;
      end
   end

   // phase tracker; an overlap keeps the old state, since the source
   // breaks its side and neither transfer may fire then
   always_comb begin
      case ({one_level, two_level})
         2'h3: begin
            next_phase = phase;
         end
         2'h2: begin
            // first phase alone
            next_phase = dual_shift_pkg::PH_ONE;
         end
         2'h1: begin
            // second phase alone
            next_phase = dual_shift_pkg::PH_TWO;
         end
         default: begin
            // both low: between pulses
            next_phase = dual_shift_pkg::PH_IDLE;
         end
      endcase
      // a transfer fires only on entry to a phase, once per pulse
      two_rise = (next_phase == dual_shift_pkg::PH_TWO) &&
                 (phase != dual_shift_pkg::PH_TWO);
      one_rise = (next_phase == dual_shift_pkg::PH_ONE) &&
                 (phase != dual_shift_pkg::PH_ONE);
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         phase <= dual_shift_pkg::PH_IDLE;
      end else begin
         phase <= next_phase;
      end
   end

   // one fifo word per phase-two pulse; empty fifo feeds zeros.
   // limitation: a source that falls behind the phase pair loses no
   // word, but zeros enter the line and starved pulses for each one
   assign fifo_take = two_rise;
   assign cell_in   = fifo_valid ? fifo_data : {W{1'b0}};

   // cell transfers: each first stage past cell 0 takes its neighbour's second
   // stage in one step, so a bit never races past a cell; the two
   // phases never fire in one cycle, which keeps both stages apart
   always_comb begin
      next_first_a  = first_a;
      next_first_b  = first_b;
      next_second_a = second_a;
      next_second_b = second_b;
      case (1'b1)
         two_rise: begin
            next_first_a = {second_a[LENGTH-2:0], cell_in[0]};
            next_first_b = {second_b[LENGTH-2:0], cell_in[1]};
         end
         one_rise: begin
            next_second_a = first_a;
            next_second_b = first_b;
         end
         default: begin
            next_second_a = second_a;
            next_second_b = second_b;
         end
      endcase
      // load with nothing to give: zeros went in
      next_starved = two_rise & ~fifo_valid;
      // both filtered levels high: source broke its side
      next_overlap = one_level & two_level;
   end

   // no functional reset exists on the real cells; reset only gives
   // simulation a defined start
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         first_a      <= '0;
         first_b      <= '0;
         second_a     <= '0;
         second_b     <= '0;
         starved      <= 1'b0;
         overlap_seen <= 1'b0;
      end else begin
         first_a      <= next_first_a;
         first_b      <= next_first_b;
         second_a     <= next_second_a;
         second_b     <= next_second_b;
         starved      <= next_starved;
         overlap_seen <= next_overlap;
      end
   end

   // last cell's second stage drives each output; flops, so registered
   assign data_out_a = second_a[LENGTH-1];
   assign data_out_b = second_b[LENGTH-1];
   // refresh rate not checked here: storage is static flops
   // the minimum rate only matters for the real dynamic cells.
   // trade-off: a watchdog on the gap between pulses would need a
   // count of system clocks per second, which this block does not know
endmodule // dual_shift_register

// >>> verilog/shift_fifo.sv
`timescale 1ns/1ps
// small first-in first-out buffer, registered read data
module shift_fifo #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 32
) (
   input  wire logic             clock,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];       // storage words
   logic [AW-1:0]    wr_ptr;            // write index
   logic [AW-1:0]    rd_ptr;            // read index
   logic [AW:0]      count;             // words held
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic [WIDTH-1:0] next_out_data;
   logic             next_out_valid;
   logic             push;
   logic             pop;

   // ready is honest: full means no room
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign push     = in_valid & in_ready;

   // output register refills when empty or being drained
   always_comb begin
      pop            = (count != '0) & (~out_valid | out_ready);
      next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr    = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count     = count + (AW+1)'(push) - (AW+1)'(pop);
      next_out_data  = pop ? mem[rd_ptr] : out_data;
      if (pop) begin
         next_out_valid = 1'b1;
      end else if (out_ready) begin
         next_out_valid = 1'b0;
      end else begin
         next_out_valid = out_valid;
      end
   end

   // registers; memory has no reset by design
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         count     <= '0;
         out_data  <= '0;
         out_valid <= 1'b0;
      end else begin
         wr_ptr    <= next_wr_ptr;
         rd_ptr    <= next_rd_ptr;
         count     <= next_count;
         out_data  <= next_out_data;
         out_valid <= next_out_valid;
      end
   end

   // memory write
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule // shift_fifo
